// ==== verilog/tccm_pkg.sv ====
// Constants for the two-channel capture/compare timer.
// Assumes an 8-bit register port with one-cycle read latency.
package tccm_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNTER_HI = 4'h1;
    localparam logic [3:0] ADDR_COUNTER_LO = 4'h2;
    localparam logic [3:0] ADDR_MODULO_HI = 4'h3;
    localparam logic [3:0] ADDR_MODULO_LO = 4'h4;
    localparam logic [3:0] ADDR_CH0_SC = 4'h5;
    localparam logic [3:0] ADDR_CH0_HI = 4'h6;
    localparam logic [3:0] ADDR_CH0_LO = 4'h7;
    localparam logic [3:0] ADDR_CH1_SC = 4'h8;
    localparam logic [3:0] ADDR_CH1_HI = 4'h9;
    localparam logic [3:0] ADDR_CH1_LO = 4'ha;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'hb;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
    // ------------------------------------------------------------
    // Timer status/control fields
    // ------------------------------------------------------------
    localparam int BIT_OVF_FLAG = 7;
    localparam int BIT_STOP = 5;
    localparam int BIT_RESET = 4;
    localparam int BIT_PS_HI = 2;
    localparam logic [2:0] PS_EXTERNAL = 3'h7;
    localparam logic [7:0] TSC_RESET = 8'h20;
    // ------------------------------------------------------------
    // Channel status/control fields
    // ------------------------------------------------------------
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_MSB = 5;
    localparam int BIT_MSA = 4;
    localparam int BIT_ELSB = 3;
    localparam int BIT_ELSA = 2;
    localparam int BIT_TOV = 1;
    localparam int BIT_MAX = 0;
    localparam logic [7:0] CHSC_RESET = 8'h00;
    localparam logic [15:0] MODULO_RESET = 16'hffff;
    // Interrupt status bits: 0 overflow, 1 channel 0, 2 channel 1
    localparam int IRQ_BITS = 3;
endpackage

// ==== verilog/tccm_timer.sv ====
// Two-channel timer with input capture, output compare and PWM.
// Assumes a register master on ref_clk and asynchronous pins.
//
// Behaviour
// (RL1) Two channels, each input capture or output compare.
// (RL2) Capture triggers on rising, falling or either edge.
// (RL3) Compare match sets, clears or toggles the pin.
// (RL4) PWM available unbuffered and buffered.
// (RL5) Counter clock from seven prescaler taps or external clock pin.
// (RL6) Counter counts up, free-running or wrapping at modulo value.
// (RL7) Per-channel toggle of pin on counter overflow.
// (RL8) Stop bit halts counter; reset bit clears it.
// (RL9) Channel pins and clock pin shared with port A pins 0..2.
// (RL10) Max-duty bit forces PWM to 0% or 100%.
// (RL11) Capture mode: active edge sets channel event flag.
// (RL12) Compare mode: counter equal to compare value sets flag.
// (RL13) Flag clears by reading it set, then writing zero.
// (RL14) New event between read and zero write keeps flag set.
// (RL15) Reset clears flag; writing one leaves it unchanged.
// (RL16) Per-channel interrupt enable, cleared by reset.
// (RL17) Buffered-mode select exists only in channel 0 register.
// (RL18) Channel request high while flag and enable are both set.
`timescale 1ns/10ps
module tccm_timer (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [2:0] portAIn,
    input wire logic [2:0] portAOut,
    input wire logic [2:0] portADir,
    output logic [2:0] portAPinOut,
    output logic [2:0] portAPinOe,
    output logic [1:0] channelIrq,
    output logic overflowIrq,
    output logic irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic [2:0] pinPrev;

    // Two stages, then a history stage for edge detection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
            pinPrev <= 3'h0;
        end else begin
            pinMeta <= portAIn;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam int IRQ_BITS_W = tccm_pkg::IRQ_BITS;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // Timer, counter and channel state
    logic [7:0] timerSc;
    logic [15:0] counter;
    logic [15:0] modulo;
    logic [7:0] chSc [2];
    logic [15:0] chVal [2];
    logic [1:0] flagArmed;
    logic [1:0] chEvent;
    logic [1:0] chOut;

    // Interrupt state
    logic [IRQ_BITS_W-1:0] irqStatus;
    logic [IRQ_BITS_W-1:0] irqMask;
    logic [IRQ_BITS_W-1:0] irqEvent;

    // Counting clock and its events
    logic [7:0] prescale;
    logic tick;
    logic overflow;
    logic extPrev;

    // Edge detection stays off until the history stage holds a real
    // pin level; a pin that idles high would otherwise look like a
    // rising edge in the first cycles after reset
    logic [1:0] settle;
    logic pinsReady;

    // Counts the first edges after reset, then holds
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            settle <= 2'h0;
        end else if (!pinsReady) begin
            settle <= settle + 2'h1;
        end
    end

    assign pinsReady = settle == SETTLE_LAST;

    // ------------------------------------------------------------
    // Prescaler and counter clock select
    // ------------------------------------------------------------
    // Free-running divider and history of the external clock pin
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= 8'h00;
            extPrev <= 1'b0;
        end else begin
            prescale <= prescale + 8'h01;
            extPrev <= pinSync[2];
        end
    end

    // Tap 2^ps of the bus clock, or rising edge of external clock
    always_comb begin
        logic [2:0] ps;
        logic [7:0] mask;
        ps = timerSc[tccm_pkg::BIT_PS_HI:0];
        mask = 8'hff >> (4'h8 - {1'b0, ps});
        if (ps == tccm_pkg::PS_EXTERNAL) begin
            tick = pinsReady & pinSync[2] & ~extPrev; // RL5
        end else begin
            tick = (prescale & mask) == 8'h00; // RL5
        end
    end

    // Overflow event: a counting tick while the count sits at modulo
    assign overflow = tick && !timerSc[tccm_pkg::BIT_STOP] &&
        counter == modulo;

    // Up-counter with modulo wrap, stop and reset controls
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            counter <= 16'h0000;
        end else if (regWr && regAddr == tccm_pkg::ADDR_STATUS_CONTROL &&
                regWdata[tccm_pkg::BIT_RESET]) begin
            counter <= 16'h0000; // RL8
        end else if (tick && !timerSc[tccm_pkg::BIT_STOP]) begin // RL8
            counter <= overflow ? 16'h0000 : counter + 16'h0001; // RL6
        end
    end

    // Timer control; reset bit is a self-clearing action
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            timerSc <= tccm_pkg::TSC_RESET;
            modulo <= tccm_pkg::MODULO_RESET;
        end else if (regWr) begin
            case (regAddr)
                tccm_pkg::ADDR_STATUS_CONTROL:
                    timerSc <= {1'b0, 1'b0, regWdata[5], 1'b0,
                        1'b0, regWdata[2:0]};
                tccm_pkg::ADDR_MODULO_HI: modulo[15:8] <= regWdata; // RL6
                tccm_pkg::ADDR_MODULO_LO: modulo[7:0] <= regWdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : gChan
        // Register addresses of this channel
        localparam logic [3:0] SC_A = c ? tccm_pkg::ADDR_CH1_SC :
            tccm_pkg::ADDR_CH0_SC;
        localparam logic [3:0] HI_A = c ? tccm_pkg::ADDR_CH1_HI :
            tccm_pkg::ADDR_CH0_HI;
        localparam logic [3:0] LO_A = c ? tccm_pkg::ADDR_CH1_LO :
            tccm_pkg::ADDR_CH0_LO;
        // Per-channel decode
        logic outputMode;
        logic edgeHit;
        logic match;
        logic buffered;
        logic [15:0] shadowVal;
        logic [15:0] compareVal;
        logic [7:0] wrMask;

        // Buffered mode only on channel 0
        assign buffered = (c == 0) && chSc[0][tccm_pkg::BIT_MSB]; // RL17
        assign outputMode = chSc[c][tccm_pkg::BIT_MSA] ||
            buffered; // RL1

        // Buffered compare value is taken over only at overflow, so a
        // new duty written mid-period never cuts the current pulse
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                shadowVal <= 16'h0000;
            end else if (!buffered || overflow) begin
                shadowVal <= chVal[c]; // RL4
            end
        end

        assign compareVal = buffered ? shadowVal : chVal[c]; // RL4

        // Active pin edge, ignored until the synchroniser has settled
        assign edgeHit = pinsReady && ((chSc[c][tccm_pkg::BIT_ELSA] &&
            pinSync[c] && !pinPrev[c]) ||
            (chSc[c][tccm_pkg::BIT_ELSB] &&
            !pinSync[c] && pinPrev[c])); // RL2

        // Compare match only on a counting tick
        assign match = tick && !timerSc[tccm_pkg::BIT_STOP] &&
            counter == compareVal;
        assign chEvent[c] = outputMode ? match : edgeHit; // RL11 RL12

        // Writable bits; the select bit exists on channel 0 only
        assign wrMask = (c == 0) ? 8'h7f : 8'h5f; // RL17

        // Channel control and event flag with clear interlock
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                chSc[c] <= tccm_pkg::CHSC_RESET; // RL15 RL16
                flagArmed[c] <= 1'b0;
            end else begin
                if (regWr && regAddr == SC_A) begin
                    chSc[c][6:0] <= regWdata[6:0] & wrMask[6:0]; // RL16
                end
                if (chEvent[c]) begin
                    chSc[c][tccm_pkg::BIT_FLAG] <= 1'b1; // RL11 RL12
                    flagArmed[c] <= 1'b0; // RL14
                end else if (regWr && regAddr == SC_A &&
                        !regWdata[tccm_pkg::BIT_FLAG] && flagArmed[c]) begin
                    chSc[c][tccm_pkg::BIT_FLAG] <= 1'b0; // RL13 RL15
                    flagArmed[c] <= 1'b0;
                end else if (regRd && regAddr == SC_A &&
                        chSc[c][tccm_pkg::BIT_FLAG]) begin
                    flagArmed[c] <= 1'b1; // RL13
                end
            end
        end

        // Capture counter on edge, or take software compare value
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                chVal[c] <= 16'h0000;
            end else if (!outputMode && edgeHit) begin
                chVal[c] <= counter; // RL11
            end else if (regWr && regAddr == HI_A) begin
                chVal[c][15:8] <= regWdata;
            end else if (regWr && regAddr == LO_A) begin
                chVal[c][7:0] <= regWdata;
            end
        end

        // Output action on match and overflow; max-duty override
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                chOut[c] <= 1'b0;
            end else if (!outputMode) begin
                chOut[c] <= 1'b0;
            end else if (chSc[c][tccm_pkg::BIT_MAX]) begin
                chOut[c] <= chSc[c][tccm_pkg::BIT_TOV]; // RL10
            end else if (match && c == 1 && chSc[0][tccm_pkg::BIT_MSB]) begin
                chOut[c] <= chOut[c];
            end else if (overflow && chSc[c][tccm_pkg::BIT_TOV]) begin
                chOut[c] <= ~chOut[c]; // RL7 RL4
            end else if (match) begin
                case (chSc[c][tccm_pkg::BIT_ELSB:tccm_pkg::BIT_ELSA])
                    2'h1: chOut[c] <= ~chOut[c]; // RL3
                    2'h2: chOut[c] <= 1'b0; // RL3
                    2'h3: chOut[c] <= 1'b1; // RL3
                    default: chOut[c] <= chOut[c];
                endcase
            end
        end

        // Interrupt request per channel
        assign channelIrq[c] = chSc[c][tccm_pkg::BIT_FLAG] &&
            chSc[c][tccm_pkg::BIT_IE]; // RL18
    end

    // ------------------------------------------------------------
    // Port A sharing
    // ------------------------------------------------------------
    // Timer owns a pin while its channel is an output; clock pin input while the external clock is selected
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (chSc[i][tccm_pkg::BIT_MSA] ||
                    (i == 0 && chSc[0][tccm_pkg::BIT_MSB])) begin
                portAPinOut[i] = chOut[i]; // RL9
                portAPinOe[i] = 1'b1;
            end else begin
                portAPinOut[i] = portAOut[i];
                portAPinOe[i] = portADir[i] &&
                    chSc[i][tccm_pkg::BIT_ELSB:tccm_pkg::BIT_ELSA] == 2'h0;
            end
        end
        portAPinOut[2] = portAOut[2];
        portAPinOe[2] = portADir[2] &&
            timerSc[2:0] != tccm_pkg::PS_EXTERNAL; // RL9
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Events that feed the sticky status
    assign irqEvent = {chEvent, overflow};

    // Sticky status, write one to clear, set wins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus <= '0;
            irqMask <= '0;
        end else begin
            if (regWr && regAddr == tccm_pkg::ADDR_IRQ_MASK) begin
                irqMask <= regWdata[IRQ_BITS_W-1:0];
            end
            if (regWr && regAddr == tccm_pkg::ADDR_IRQ_STATUS) begin
                irqStatus <= (irqStatus & ~regWdata[IRQ_BITS_W-1:0]) |
                    irqEvent;
            end else begin
                irqStatus <= irqStatus | irqEvent;
            end
        end
    end

    // Overflow level and the masked summary request
    assign overflowIrq = irqStatus[0];
    assign irq = |(irqStatus & irqMask);

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                tccm_pkg::ADDR_STATUS_CONTROL:
                    regRdata <= {irqStatus[0], timerSc[6:0]};
                tccm_pkg::ADDR_COUNTER_HI: regRdata <= counter[15:8];
                tccm_pkg::ADDR_COUNTER_LO: regRdata <= counter[7:0];
                tccm_pkg::ADDR_MODULO_HI: regRdata <= modulo[15:8];
                tccm_pkg::ADDR_MODULO_LO: regRdata <= modulo[7:0];
                tccm_pkg::ADDR_CH0_SC: regRdata <= chSc[0];
                tccm_pkg::ADDR_CH0_HI: regRdata <= chVal[0][15:8];
                tccm_pkg::ADDR_CH0_LO: regRdata <= chVal[0][7:0];
                tccm_pkg::ADDR_CH1_SC: regRdata <= chSc[1];
                tccm_pkg::ADDR_CH1_HI: regRdata <= chVal[1][15:8];
                tccm_pkg::ADDR_CH1_LO: regRdata <= chVal[1][7:0];
                tccm_pkg::ADDR_IRQ_STATUS:
                    regRdata <= {5'h00, irqStatus};
                tccm_pkg::ADDR_IRQ_MASK: regRdata <= {5'h00, irqMask};
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule

// ==== testbench/tccm_timer_chk.sv ====
// Port checker for the two-channel capture/compare timer.
// Assumes it is bound to tccm_timer; one clock domain.
`timescale 1ns/10ps
module tccm_timer_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic [2:0] portAIn,
    input wire logic [2:0] portAOut,
    input wire logic [2:0] portADir,
    input wire logic [2:0] portAPinOut,
    input wire logic [2:0] portAPinOe,
    input wire logic [1:0] channelIrq,
    input wire logic overflowIrq,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic extSel;

    // Mirror of the clock source choice, taken from register writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            extSel <= 1'b0;
        end else if (regWr && regAddr == tccm_pkg::ADDR_STATUS_CONTROL) begin
            extSel <= regWdata[2:0] == tccm_pkg::PS_EXTERNAL;
        end
    end
    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    sequence rdCh0;
        regRd && regAddr == tccm_pkg::ADDR_CH0_SC;
    endsequence
    sequence rdCh1;
        regRd && regAddr == tccm_pkg::ADDR_CH1_SC;
    endsequence
    rd_idle_zero_a: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    ch1_msb_zero_a: assert property (rdCh1 |=> !regRdata[5])
        else $error("channel 1 shows a buffered select bit");
    flag_irq_tie_a: assert property (rdCh0 ##1 regRdata[6] |->
        regRdata[7] == $past(channelIrq[0]))
        else $error("channel 0 request disagrees with flag");
    // ------------------------------------------------------------
    // Requests drop only on software writes
    // ------------------------------------------------------------
    ch0_irq_fall_a: assert property ($fell(channelIrq[0]) |->
        $past(regWr && regAddr == tccm_pkg::ADDR_CH0_SC))
        else $error("channel 0 request dropped without a write");
    ch1_irq_fall_a: assert property ($fell(channelIrq[1]) |->
        $past(regWr && regAddr == tccm_pkg::ADDR_CH1_SC))
        else $error("channel 1 request dropped without a write");
    ovf_fall_a: assert property ($fell(overflowIrq) |->
        $past(regWr && regAddr == tccm_pkg::ADDR_IRQ_STATUS))
        else $error("overflow request dropped without a write");
    // ------------------------------------------------------------
    // Shared clock pin stays a port pin
    // ------------------------------------------------------------
    clk_pin_oe_a: assert property (portAPinOe[2] ==
        (portADir[2] && !extSel))
        else $error("clock pin enable wrong for the clock source");
    clk_pin_out_a: assert property (portAPinOe[2] |->
        portAPinOut[2] == portAOut[2])
        else $error("clock pin value not from port data");
endmodule

bind tccm_timer tccm_timer_chk chk (.ref_clk(ref_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .portAIn(portAIn), .portAOut(portAOut),
    .portADir(portADir), .portAPinOut(portAPinOut),
    .portAPinOe(portAPinOe), .channelIrq(channelIrq),
    .overflowIrq(overflowIrq), .irq(irq));

// ==== testbench/tccm_pins.sv ====
// Model of the outside world on the three shared port pins.
// Assumes a pull-up on each pin when nobody drives it.
`timescale 1ns/10ps
module tccm_pins (
    input wire logic [2:0] portAPinOut,
    input wire logic [2:0] portAPinOe,
    input wire logic [2:0] extDrive,
    input wire logic [2:0] extEn,
    output logic [2:0] portAIn
);
    // Pin level: device drive first, outside source next, else pulled up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            portAIn[i] = portAPinOe[i] ? portAPinOut[i]
                : (extEn[i] ? extDrive[i] : 1'b1);
        end
    end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the capture/compare timer.
// Assumes tccm_timer, the pin model and the bound checker.
`timescale 1ns/10ps
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [2:0] portAIn;
    logic [2:0] portAOut = 3'h0;
    logic [2:0] portADir = 3'h0;
    logic [2:0] portAPinOut;
    logic [2:0] portAPinOe;
    logic [2:0] extDrive = 3'h7;
    logic [2:0] extEn = 3'h3;
    logic [1:0] channelIrq;
    logic overflowIrq;
    logic irq;
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'h314290b9;
    int m;
    logic [7:0] d;
    logic [7:0] r;
    always #2 ref_clk = ~ref_clk;
    tccm_timer dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .portAIn(portAIn), .portAOut(portAOut),
        .portADir(portADir), .portAPinOut(portAPinOut),
        .portAPinOe(portAPinOe), .channelIrq(channelIrq),
        .overflowIrq(overflowIrq), .irq(irq));
    tccm_pins pins (.portAPinOut(portAPinOut), .portAPinOe(portAPinOe),
        .extDrive(extDrive), .extEn(extEn), .portAIn(portAIn));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        v = regRdata;
    endtask
    task automatic pin0(input logic v);
        @(posedge ref_clk);
        extDrive[0] <= v;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic finish_test;
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(tccm_pkg::ADDR_STATUS_CONTROL, d);
        chk("timer ctl", d, tccm_pkg::TSC_RESET);
        rd(tccm_pkg::ADDR_CH0_SC, d);
        chk("ch0 sc", d, tccm_pkg::CHSC_RESET);
        rd(tccm_pkg::ADDR_CH1_SC, d);
        chk("ch1 sc", d, tccm_pkg::CHSC_RESET);
        rd(4'hf, d);
        chk("unmapped", d, 8'h00);
        wr(tccm_pkg::ADDR_CH1_SC, 8'hff);
        rd(tccm_pkg::ADDR_CH1_SC, d);
        chk("ch1 sc all", d, 8'h5f);
        wr(tccm_pkg::ADDR_CH1_SC, 8'h00);
        // Random port data passes to the pins; modulo reads back
        portADir <= 3'h7;
        extEn <= 3'h0;
        for (m = 0; m < 4; m++) begin
            r = 8'($random(seed));
            portAOut <= r[2:0];
            wr(tccm_pkg::ADDR_MODULO_LO, r);
            rd(tccm_pkg::ADDR_MODULO_LO, d);
            chk("modulo lo", d, r);
            chk("pin out", {5'h0, portAPinOut}, {5'h0, r[2:0]});
            chk("pin oe", {5'h0, portAPinOe}, 8'h07);
        end
        portADir <= 3'h0;
        extEn <= 3'h3;
        // Let the pins settle before any edge mode is armed
        repeat (4) @(posedge ref_clk);
        // Every capture edge mode, falling then rising edge
        for (m = 1; m < 4; m++) begin
            r = 8'h40 | 8'(m << 2);
            wr(tccm_pkg::ADDR_CH0_SC, r);
            pin0(1'b0);
            rd(tccm_pkg::ADDR_CH0_SC, d);
            chk("ch0 fall", d, r | (m != 1 ? 8'h80 : 8'h00));
            chk("ch0 irq", {7'h0, channelIrq[0]}, 8'(m != 1));
            wr(tccm_pkg::ADDR_CH0_SC, r);
            pin0(1'b1);
            rd(tccm_pkg::ADDR_CH0_SC, d);
            chk("ch0 rise", d, r | (m != 2 ? 8'h80 : 8'h00));
            wr(tccm_pkg::ADDR_CH0_SC, r);
        end
        // Interrupt status, mask and clear
        wr(tccm_pkg::ADDR_IRQ_MASK, 8'h02);
        #1 chk("irq on", {7'h0, irq}, 8'h01);
        wr(tccm_pkg::ADDR_IRQ_MASK, 8'h00);
        #1 chk("irq off", {7'h0, irq}, 8'h00);
        wr(tccm_pkg::ADDR_IRQ_STATUS, 8'h07);
        rd(tccm_pkg::ADDR_IRQ_STATUS, d);
        chk("irq status", d, 8'h00);
        // New event between read and zero write keeps the flag
        pin0(1'b0);
        rd(tccm_pkg::ADDR_CH0_SC, d);
        pin0(1'b1);
        wr(tccm_pkg::ADDR_CH0_SC, r);
        rd(tccm_pkg::ADDR_CH0_SC, d);
        chk("flag kept", d, r | 8'h80);
        wr(tccm_pkg::ADDR_CH0_SC, r);
        wr(tccm_pkg::ADDR_CH0_SC, r | 8'h80);
        rd(tccm_pkg::ADDR_CH0_SC, d);
        chk("flag cleared", d, r);
        // Channel 1 compare sets its pin; modulo 8 gives overflow
        extEn <= 3'h1;
        wr(tccm_pkg::ADDR_MODULO_HI, 8'h00);
        wr(tccm_pkg::ADDR_MODULO_LO, 8'h08);
        wr(tccm_pkg::ADDR_CH1_HI, 8'h00);
        wr(tccm_pkg::ADDR_CH1_LO, 8'h03);
        wr(tccm_pkg::ADDR_CH1_SC, 8'h5c);
        wr(tccm_pkg::ADDR_STATUS_CONTROL, 8'h00);
        m = 0;
        while (channelIrq[1] !== 1'b1 && m < 50) begin
            @(posedge ref_clk);
            m++;
        end
        if (m == 50) begin
            errors++;
            finish_test;
        end
        repeat (20) @(posedge ref_clk);
        #1 chk("ovf irq", {7'h0, overflowIrq}, 8'h01);
        chk("ch1 pin", {6'h0, portAPinOe[1], portAPinOut[1]}, 8'h03);
        wr(tccm_pkg::ADDR_STATUS_CONTROL, 8'h30);
        rd(tccm_pkg::ADDR_COUNTER_LO, d);
        chk("counter", d, 8'h00);
        rd(tccm_pkg::ADDR_CH1_SC, d);
        chk("ch1 match", d, 8'hdc);
        wr(tccm_pkg::ADDR_CH1_SC, 8'h5c);
        wr(tccm_pkg::ADDR_IRQ_STATUS, 8'h01);
        #1 chk("irq clear", {6'h0, channelIrq[1], overflowIrq}, 8'h00);
        // External clock: five rising edges on pin 2 give five counts
        extEn <= 3'h5;
        wr(tccm_pkg::ADDR_STATUS_CONTROL, 8'h17);
        portADir <= 3'h4;
        for (m = 0; m < 5; m++) begin
            extDrive[2] <= 1'b0;
            repeat (4) @(posedge ref_clk);
            extDrive[2] <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        chk("clk pin oe", {7'h0, portAPinOe[2]}, 8'h00);
        wr(tccm_pkg::ADDR_STATUS_CONTROL, 8'h27);
        rd(tccm_pkg::ADDR_COUNTER_LO, d);
        chk("ext count", d, 8'h05);
        finish_test;
    end
endmodule
